// ---- lut_pkg.sv ----
// shared types and constants for the pixel lookup table block
// assumes one 25 MHz clock domain and an APB register port
package lut_pkg;

  // register map, byte address on the APB port
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // table geometry
  localparam int LANE_COUNT = 4;
  localparam int BANK_COUNT = 4;
  localparam int ENTRY_COUNT = 256;
  localparam int SLOT_COUNT = BANK_COUNT * ENTRY_COUNT;
  localparam int BUFFER_DEPTH = 2;

  // control word, fields from bit 31 down to bit 0
  typedef struct packed {
    logic access_en;      // host_table_access_enable, bit 31
    logic write_strobe;   // table_write_strobe, bit 30
    logic [1:0] lane;     // host_lane_select, bits 29..28
    logic write_mode;     // data_write_mode, bit 27
    logic rsv_26;         // reserved, reads zero
    logic [1:0] bank;     // table_bank_select, bits 25..24
    logic [7:0] index;    // host_table_index, bits 23..16
    logic path_en;        // table_path_enable, bit 15
    logic [6:0] rsv_14_8; // reserved, reads zero
    logic [7:0] data;     // host_table_data, bits 7..0
  } lookup_table_control_t;

  // one camera pixel word, one byte per lane
  typedef struct packed {
    logic [LANE_COUNT-1:0][7:0] lane;
  } pixel_word_t;

endpackage

// ---- pixel_lookup_table.sv ----
// pixel lookup table with indirect host access over APB
// assumes APB master on sys_clk_i and a pixel source that honours ready
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
module pixel_lookup_table
  import lut_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire pixel_word_t pix_data_i,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output pixel_word_t pix_data_o
);

  // table slot from bank and index, shared by host and pixel path
  function automatic logic [9:0] table_slot(input logic [1:0] bank, input logic [7:0] index);
    table_slot = {bank, index};
  endfunction

  // byte-lane merge of an APB write into a stored word
  function automatic logic [31:0] apply_strobes(input logic [31:0] old_word, input logic [31:0] new_word,
                                                input logic [3:0] strb);
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merged[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    apply_strobes = merged;
  endfunction

  lookup_table_control_t ctrl;
  lookup_table_control_t next_ctrl;
  logic [7:0] table_mem [LANE_COUNT][SLOT_COUNT];
  logic answer_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic apb_access;
  logic apb_hit;
  logic wr_fire;
  logic mem_we;
  logic [1:0] we_lane;
  logic [9:0] we_slot;
  logic [7:0] we_data;
  logic [7:0] host_entry;
  logic [31:0] read_word;
  pixel_word_t translated;
  logic buf_in_ready;

  // APB: one wait state so read data comes from a flip-flop
  assign apb_access = psel_i && penable_i;
  assign apb_hit = (paddr_i == CTRL_OFFSET);
  assign pready_o = apb_access && answer_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pready_o && slverr_q;
  assign wr_fire = pready_o && pwrite_i && apb_hit;

  // entry under the host pointer, blocked when access is off
  assign host_entry = ctrl.access_en ?
    table_mem[ctrl.lane][table_slot(ctrl.bank, ctrl.index)] : 8'h00;

  // read-back word: strobe and reserved bits read as zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_word[31] = ctrl.access_en;
    read_word[29:28] = ctrl.lane;
    read_word[27] = ctrl.write_mode;
    read_word[25:24] = ctrl.bank;
    read_word[23:16] = ctrl.index;
    read_word[15] = ctrl.path_en;
    if (ctrl.write_mode)
    begin
      read_word[7:0] = ctrl.data;
    end
    else
    begin
      read_word[7:0] = host_entry;
    end
  end

  // answer phase flags and registered read data
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      answer_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (apb_access && !answer_q)
    begin
      answer_q <= 1'b1;
      prdata_q <= (!pwrite_i && apb_hit) ? read_word : 32'h0000_0000;
      slverr_q <= !apb_hit; // unmapped address answers with an error
    end
    else
    begin
      answer_q <= 1'b0;
      prdata_q <= prdata_q;
      slverr_q <= 1'b0;
    end
  end

  // written fields; the data byte only takes writes in write mode
  always_comb
  begin
    next_ctrl = lookup_table_control_t'(apply_strobes(32'(ctrl), pwdata_i, pstrb_i));
    next_ctrl.rsv_26 = 1'b0;
    next_ctrl.rsv_14_8 = 7'h00;
    if (!next_ctrl.write_mode)
    begin
      next_ctrl.data = ctrl.data;
    end
  end

  // table commit: strobe with write mode and access both set
  assign mem_we = wr_fire && next_ctrl.write_strobe && next_ctrl.write_mode && next_ctrl.access_en;
  assign we_lane = next_ctrl.lane;
  assign we_slot = table_slot(next_ctrl.bank, next_ctrl.index);
  assign we_data = next_ctrl.data;

  // control register; the strobe is never stored, it is write-only
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl <= lookup_table_control_t'(CTRL_RESET);
    end
    else if (wr_fire)
    begin
      ctrl <= next_ctrl;
      ctrl.write_strobe <= 1'b0;
    end
  end

  // table memory has no reset; software loads it before use
  always_ff @(posedge sys_clk_i)
  begin
    if (mem_we)
    begin
      table_mem[we_lane][we_slot] <= we_data;
    end
  end

  // pixel translation: each lane indexes its own lane of the active bank
  always_comb
  begin
    translated = pix_data_i;
    if (ctrl.path_en)
    begin
      for (int l = 0; l < LANE_COUNT; l++)
      begin
        translated.lane[l] = table_mem[l][table_slot(ctrl.bank, pix_data_i.lane[l])];
      end
    end
  end

  // buffer holds words while the receiver stalls
  pixel_pair_buffer out_buffer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(buf_in_ready),
    .in_data_i(translated),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(pix_data_o)
  );

  assign pix_ready_o = buf_in_ready;

  // helper copies of the last table write for the checks below
  logic [1:0] last_lane;
  logic [9:0] last_slot;
  logic [7:0] last_data;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      last_lane <= 2'h0;
      last_slot <= 10'h000;
      last_data <= 8'h00;
    end
    else if (mem_we)
    begin
      last_lane <= we_lane;
      last_slot <= we_slot;
      last_data <= we_data;
    end
  end

  a_bypass_data: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (pix_valid_i && pix_ready_o && !ctrl.path_en) |-> (translated == pix_data_i))
  else $error("bypass changed pixel data");

  a_lane_lookup: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (pix_valid_i && ctrl.path_en) |->
      (translated.lane[3] == table_mem[3][{ctrl.bank, pix_data_i.lane[3]}]))
  else $error("lane three not translated through its own lane");

  a_entry_written: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    mem_we |=> (table_mem[last_lane][last_slot] == last_data) && (ctrl.data == last_data))
  else $error("strobe did not store the held byte");

  // access and mode come from the written byte when its lane is strobed, else from the held word
  a_write_gated: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    mem_we |-> (wr_fire && (pstrb_i[3] ? (pwdata_i[31] && pwdata_i[27]) : (ctrl.access_en && ctrl.write_mode))))
  else $error("table written without access or write mode");

  a_strobe_commits: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_fire && pstrb_i[3] && (pwdata_i[31:30] == 2'h3) && pwdata_i[27]) |-> mem_we)
  else $error("strobe in write mode was lost");

  a_read_entry: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !answer_q && !pwrite_i && apb_hit && ctrl.access_en && !ctrl.write_mode)
      |=> (prdata_o[7:0] == $past(host_entry)) && pready_o)
  else $error("read mode did not return the table entry");

  a_hold_readback: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_fire && pstrb_i[3] && pstrb_i[0] && pwdata_i[27]) |=> (ctrl.data == $past(pwdata_i[7:0])))
  else $error("write mode byte not held");

  // a read in write mode hands back the held byte, not the table entry
  a_hold_read: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !answer_q && !pwrite_i && apb_hit && ctrl.write_mode)
      |=> (prdata_o[7:0] == $past(ctrl.data)))
  else $error("write mode read did not return held byte");

  // in read mode a write leaves the data byte untouched
  a_data_readonly: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_fire && pstrb_i[3] && !pwdata_i[27]) |=> (ctrl.data == $past(ctrl.data)))
  else $error("data byte written in read mode");

  a_blocked_read: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !answer_q && !pwrite_i && apb_hit && !ctrl.access_en && !ctrl.write_mode)
      |=> (prdata_o[7:0] == 8'h00))
  else $error("table read while access is off");

  a_strobe_zero: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    pready_o |-> !prdata_o[30] && !prdata_o[26] && (prdata_o[14:8] == 7'h00))
  else $error("write-only or reserved bit read back");

  a_unmapped_err: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !apb_hit) |-> ##[0:1] (pready_o && pslverr_o))
  else $error("unmapped address not refused");

  a_stall_holds: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (pix_valid_o && !pix_ready_i) |=> pix_valid_o && $stable(pix_data_o))
  else $error("stalled pixel word changed or dropped");

  a_ctrl_stable: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !wr_fire |=> $stable(ctrl.bank) && $stable(ctrl.path_en))
  else $error("bank or path select changed without a write");

  // a full-word programming write lands at the lane, bank and index it names
  a_entry_location: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_fire && (pstrb_i == 4'hF) && (pwdata_i[31:30] == 2'h3) && pwdata_i[27])
      |=> (table_mem[$past(pwdata_i[29:28])][{$past(pwdata_i[25:24]), $past(pwdata_i[23:16])}]
           == $past(pwdata_i[7:0])))
  else $error("table entry stored at the wrong location");

  // one wait state: the first access cycle always arms the answer
  a_answer_wait: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !answer_q) |=> answer_q)
  else $error("apb answer not armed after first access cycle");

  // a refused address must leave the control word as it was
  a_unmapped_still: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (apb_access && !apb_hit) |=> $stable(ctrl))
  else $error("unmapped write changed the control word");

  // the input is only refused while the buffer has a word to offer
  a_refuse_full: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !pix_ready_o |-> pix_valid_o)
  else $error("input refused with an empty buffer");

endmodule // pixel_lookup_table

// ---- pixel_lookup_table_bench.sv ----
// self-checking bench for the pixel lookup table block
// assumes lut_pkg, the block, its buffer and the pixel sink model
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module pixel_lookup_table_bench
  import lut_pkg::*;
;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic in_valid = 1'h0, in_ready, out_valid, out_ready, stall = 1'h0, taken;
  pixel_word_t in_data = '0, out_data, word;
  logic [7:0] tbl [4][4][256];
  pixel_word_t expq [$];
  pixel_word_t exp_word;
  integer seed = 32'h23ecba21;
  int n_fail = 0, checks = 0, refusals = 0;

  pixel_lookup_table u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .pix_valid_i(in_valid), .pix_ready_o(in_ready), .pix_data_i(in_data),
    .pix_valid_o(out_valid), .pix_ready_i(out_ready), .pix_data_o(out_data));
  pixel_sink_model u_sink (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .valid_i(out_valid), .data_i(out_data),
    .stall_i(stall), .ready_o(out_ready), .taken_o(taken), .word_o(word));

  always #20 sys_clk_i = ~sys_clk_i;

  task automatic stop_test();
  begin
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  function automatic logic [31:0] ctl(logic a, s, logic [1:0] l, logic m, logic [1:0] b, logic [7:0] i, logic p,
    logic [7:0] d);
    return {a, s, l, m, 1'h0, b, i, p, 7'h00, d};
  endfunction

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
  begin
    @(posedge sys_clk_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk_i);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      k++;
    end
    while (pready !== 1'h1 && k < 16);
    if (pready !== 1'h1)
    begin
      n_fail++;
      $display("ERROR %0t: apb answer timed out", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~wd;
  end
  endtask

  task automatic prog(input logic [1:0] b, l, input logic [7:0] i, d);
  begin
    apb(1'h1, CTRL_OFFSET, ctl(1'h1, 1'h1, l, 1'h1, b, i, 1'h0, d));
    tbl[l][b][i] = d;
  end
  endtask

  task automatic peek(input logic [1:0] b, l, input logic [7:0] i);
  begin
    apb(1'h1, CTRL_OFFSET, ctl(1'h1, 1'h0, l, 1'h0, b, i, 1'h0, 8'h00));
    apb(1'h0, CTRL_OFFSET, 32'h0);
    `CHK(rd, ctl(1'h1, 1'h0, l, 1'h0, b, i, 1'h0, tbl[l][b][i]))
  end
  endtask

  // source: notes the translated word as each one is taken
  task automatic send(input int n, input logic p, input logic [1:0] b, input logic [7:0] m);
    pixel_word_t w, x;
    int k;
  begin
    for (int j = 0; j < n; j++)
    begin
      w = $random(seed) & {4{m}};
      for (k = 0; k < 4; k++)
        x.lane[k] = p ? tbl[k][b][w.lane[k]] : w.lane[k];
      in_valid <= 1'h1;
      in_data <= w;
      do @(posedge sys_clk_i); while (in_ready !== 1'h1);
      expq.push_back(x);
    end
    in_valid <= 1'h0;
    in_data <= ~w;
    for (k = 0; k < 200 && expq.size() > 0; k++)
      @(posedge sys_clk_i);
    `CHK(expq.size(), 0)
  end
  endtask

  // watcher: each word the sink takes is matched to the oldest note
  always @(posedge sys_clk_i)
  begin
    if (in_valid && in_ready === 1'h0)
      refusals++;
    if (taken === 1'h1)
    begin
      `CHK(expq.size() > 0, 1'h1)
      if (expq.size() > 0)
      begin
        exp_word = expq.pop_front();
        `CHK(word, exp_word)
      end
    end
  end

  // watchdog well beyond the expected run of about 1000 cycles
  initial
  begin
    #(40 * 30000);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    apb(1'h0, CTRL_OFFSET, 32'h0);
    `CHK({er, rd}, {1'h0, CTRL_RESET})
    apb(1'h0, 8'h04, 32'h0);
    `CHK({er, rd}, {1'h1, 32'h0})
    apb(1'h1, 8'h08, 32'hFFFFFFFF);
    apb(1'h0, CTRL_OFFSET, 32'h0);
    `CHK(rd, CTRL_RESET)
    $display("test register done");
    for (int k = 0; k < 128; k++)
      prog(k[6:5], k[4:3], {5'h00, k[2:0]}, 8'($random(seed)));
    for (int k = 0; k < 16; k++)
      peek(k[3:2], k[1:0], 8'($random(seed)) & 8'h07);
    $display("test table done");
    apb(1'h1, CTRL_OFFSET, ctl(1'h1, 1'h1, 2'h1, 1'h0, 2'h2, 8'h03, 1'h0, ~tbl[1][2][3]));
    peek(2'h2, 2'h1, 8'h03);
    apb(1'h1, CTRL_OFFSET, ctl(1'h1, 1'h0, 2'h1, 1'h1, 2'h2, 8'h03, 1'h0, 8'h5A));
    apb(1'h0, CTRL_OFFSET, 32'h0);
    `CHK(rd, ctl(1'h1, 1'h0, 2'h1, 1'h1, 2'h2, 8'h03, 1'h0, 8'h5A))
    peek(2'h2, 2'h1, 8'h03);
    apb(1'h1, CTRL_OFFSET, ctl(1'h0, 1'h1, 2'h1, 1'h1, 2'h2, 8'h03, 1'h0, 8'hA5));
    apb(1'h1, CTRL_OFFSET, ctl(1'h0, 1'h0, 2'h1, 1'h0, 2'h2, 8'h03, 1'h0, 8'h00));
    apb(1'h0, CTRL_OFFSET, 32'h0);
    `CHK(rd, ctl(1'h0, 1'h0, 2'h1, 1'h0, 2'h2, 8'h03, 1'h0, 8'h00))
    peek(2'h2, 2'h1, 8'h03);
    $display("test host access done");
    send(20, 1'h0, 2'h0, 8'hFF);
    stall <= 1'h1;
    send(40, 1'h0, 2'h0, 8'hFF);
    apb(1'h1, CTRL_OFFSET, ctl(1'h0, 1'h0, 2'h0, 1'h0, 2'h2, 8'h00, 1'h1, 8'h00));
    send(40, 1'h1, 2'h2, 8'h07);
    apb(1'h1, CTRL_OFFSET, ctl(1'h0, 1'h0, 2'h0, 1'h0, 2'h3, 8'h00, 1'h1, 8'h00));
    send(40, 1'h1, 2'h3, 8'h07);
    `CHK(refusals > 0, 1'h1)
    $display("test pixel path done");
    stop_test();
  end
endmodule // pixel_lookup_table_bench

// ---- pixel_pair_buffer.sv ----
// two-entry buffer for pixel words with valid/ready on both sides
// assumes the same clock and reset as the table block
`timescale 1ns/100ps
module pixel_pair_buffer
  import lut_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire pixel_word_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output pixel_word_t out_data_o
);

  pixel_word_t slot [BUFFER_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // full when both slots hold a word, so a stalled reader loses nothing
  assign in_ready_o = (count != 2'(BUFFER_DEPTH));
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = slot[rd_ptr];

  // storage needs no reset, the count guards it
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      slot[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end

endmodule // pixel_pair_buffer

// ---- pixel_sink_model.sv ----
// pixel receiver model at the far side of the table block
// assumes lut_pkg and the same clock and reset as the block
`timescale 1ns/100ps
module pixel_sink_model
  import lut_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic valid_i,
  input wire pixel_word_t data_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic taken_o,
  output pixel_word_t word_o
);
  integer seed = 32'h23ecba21;

  // random stalls let the buffer fill up and refuse
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ready_o <= 1'h0;
      taken_o <= 1'h0;
      word_o <= '0;
    end
    else
    begin
      ready_o <= stall_i ? 1'($random(seed)) : 1'h1;
      taken_o <= valid_i && ready_o; // reported one cycle after the take
      word_o <= data_i;
    end
  end
endmodule // pixel_sink_model
